/* hw/sag_map.svh */
// address map, field positions and bus register offsets of the sfr access guard
`ifndef SAG_MAP_SVH
`define SAG_MAP_SVH

// register group bounds
`define SAG_SYS_LO   8'h90
`define SAG_SEG_LO   8'hA0
`define SAG_FW_LO    8'hA8
`define SAG_CLOS_LO  8'hB0
`define SAG_HW_LO    8'hC0
// registers held or watched here
`define SAG_PROGRAM_STATUS_HIGH     8'h90
`define SAG_RSV0     8'h9D
`define SAG_RSV1     8'h9E
`define SAG_RSV2     8'h9F
`define SAG_SEGT_L   8'hA0
`define SAG_SEGT_H   8'hA1
`define SAG_FWR_L    8'hA8
`define SAG_FWR_H    8'hA9
`define SAG_XB_L     8'hAA
`define SAG_XB_H     8'hAB
`define SAG_XS_L     8'hAC
`define SAG_XS_H     8'hAD
`define SAG_CLOCK_SELECTION_REG   8'hC0
`define SAG_RNG      8'hD0
`define SAG_KEYA     8'hE0
`define SAG_KEYD     8'hE1
// fields
`define SAG_PSW_SYS  7
`define SAG_PSW_CLOS 6
`define SAG_HW_IDX   5:2
`define SAG_CTRL_LOG 0
`define SAG_CTRL_CLR 1
// bus register offsets
`define SAG_AX_CTRL  8'h00
`define SAG_AX_STAT  8'h04
`define SAG_AX_DENY  8'h08
`define SAG_AX_LAST  8'h0C
`define SAG_AX_FWR   8'h10
`define SAG_AX_XB    8'h14
`define SAG_AX_XS    8'h18
`define SAG_AX_SEGT  8'h1C
`define SAG_OKAY     2'h0
`define SAG_SLVERR   2'h2
`endif

/* hw/sag_pkg.sv */
// types of the sfr access guard
package sag_pkg;
   typedef enum logic [2:0] {SAG_BOOT, SAG_TEST, SAG_CLOS, SAG_SYS, SAG_USER} sag_mode_t;
   typedef enum logic [2:0] {GRP_GEN, GRP_SYS, GRP_SEG, GRP_FW, GRP_CLOS, GRP_HW} sag_grp_t;
   typedef struct packed {
      logic [7:0]  psw;
      logic [15:0] segt;
      logic [15:0] fwr;
      logic [15:0] xb;
      logic [15:0] xs;
      logic        s_vld;
      logic        s_rd;
      logic        s_wr;
      logic        s_ok;
      logic        s_own;
      logic [7:0]  s_addr;
      logic [7:0]  s_wdata;
      logic [7:0]  s_ldata;
      logic        c_ack;
      logic        c_denied;
      logic [7:0]  c_rdata;
      logic [2:0]  mode;
      logic        log_en;
      logic [15:0] deny_cnt;
      logic [11:0] last;
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic        w_strb0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } sag_state_t;
endpackage

/* hw/sag_mode_dec.sv */
// cpu mode derivation from program status high and internal state bits
`timescale 1ns/1ps
`default_nettype none
`include "sag_map.svh"
module sag_mode_dec
   import sag_pkg::*;
(
   // mode sources
   input  wire logic [7:0] psw,
   input  wire logic       boot_state,
   input  wire logic       test_state,
   // derived mode
   output var  sag_mode_t  mode
);
   always_comb begin
      if (boot_state) begin
         mode = SAG_BOOT;
      end else if (test_state) begin
         mode = SAG_TEST;
      end else if (psw[`SAG_PSW_CLOS]) begin
         mode = SAG_CLOS;
      end else if (psw[`SAG_PSW_SYS]) begin
         mode = SAG_SYS;
      end else begin
         mode = SAG_USER;
      end
   end
endmodule // sag_mode_dec
`default_nettype wire

/* hw/sag_policy.sv */
// grant or deny decision for one register access
`timescale 1ns/1ps
`default_nettype none
`include "sag_map.svh"
module sag_policy
   import sag_pkg::*;
(
   // access
   input  wire logic [7:0]  addr,
   input  wire logic        wr,
   input  wire sag_mode_t   mode,
   // rights
   input  wire logic [15:0] fw_rights,
   input  wire logic [15:0] seg_rights,
   // decision
   output logic             grant
);
   function automatic sag_grp_t grp_of(input logic [7:0] a);
      if (a < `SAG_SYS_LO) grp_of = GRP_GEN;
      else if (a < `SAG_SEG_LO) grp_of = GRP_SYS;
      else if (a < `SAG_FW_LO) grp_of = GRP_SEG;
      else if (a < `SAG_CLOS_LO) grp_of = GRP_FW;
      else if (a < `SAG_HW_LO) grp_of = GRP_CLOS;
      else grp_of = GRP_HW;
   endfunction

   sag_grp_t grp;
   logic     psw_rd;
   assign grp = grp_of(addr);
   assign psw_rd = !wr && addr == `SAG_PROGRAM_STATUS_HIGH;

   always_comb begin
      unique case (mode)
         SAG_BOOT, SAG_TEST: grant = 1'h1;
         SAG_CLOS: begin
            unique case (grp)
               GRP_GEN:  grant = 1'h1;
               GRP_FW:   grant = !wr;
               GRP_CLOS: grant = 1'h1;
               GRP_SYS:  grant = psw_rd;
               GRP_HW:   grant = fw_rights[addr[`SAG_HW_IDX]]
                                 || (!wr && addr == `SAG_CLOCK_SELECTION_REG);
               default:  grant = 1'h0;
            endcase
         end
         SAG_SYS: grant = grp != GRP_CLOS;
         SAG_USER: begin
            unique case (grp)
               GRP_GEN: grant = 1'h1;
               GRP_SYS: grant = psw_rd;
               GRP_HW:  grant = seg_rights[addr[`SAG_HW_IDX]];
               default: grant = 1'h0;
            endcase
         end
         default: grant = 1'h0;
      endcase
      if (grp == GRP_SEG && mode != SAG_SYS) grant = 1'h0;
      if (!wr && (addr == `SAG_RSV0 || addr == `SAG_RSV1 || addr == `SAG_RSV2))
         grant = 1'h0;
      if (wr && addr == `SAG_RNG) grant = 1'h0;
      if (!wr && (addr == `SAG_KEYA || addr == `SAG_KEYD)) grant = 1'h0;
   end
endmodule // sag_policy
`default_nettype wire

/* hw/sag_guard.sv */
// sfr access guard top: cpu port, sfr file port and bus register slave
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sag_map.svh"
module sag_guard
   import sag_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // cpu register access
   input  wire logic        cpu_req,
   input  wire logic        cpu_wr,
   input  wire logic [7:0]  cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   output logic             cpu_ack,
   output logic             cpu_denied,
   output logic [7:0]       cpu_rdata,
   // mode sources and segment rights
   input  wire logic        boot_state,
   input  wire logic        test_state,
   input  wire logic [15:0] seg_hw_rights,
   output logic [2:0]       cpu_mode,
   // register file side
   output logic             sfr_rd,
   output logic             sfr_wr,
   output logic [7:0]       sfr_addr,
   output logic [7:0]       sfr_wdata,
   input  wire logic [7:0]  sfr_rdata,
   // memory unit side
   output logic [15:0]      seg_table_addr,
   output logic [15:0]      xchg_base,
   output logic [15:0]      xchg_size,
   // bus write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // bus read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam sag_state_t SAG_RST = '{log_en: 1'h1, default: '0};

   sag_state_t q;
   sag_state_t n;
   sag_mode_t  cur_mode;
   logic       grant;
   logic       own;
   logic [7:0] lread;

   sag_mode_dec u_mode (
      .psw        (q.psw),
      .boot_state (boot_state),
      .test_state (test_state),
      .mode       (cur_mode)
   );

   sag_policy u_policy (
      .addr       (cpu_addr),
      .wr         (cpu_wr),
      .mode       (cur_mode),
      .fw_rights  (q.fwr),
      .seg_rights (seg_hw_rights),
      .grant      (grant)
   );

   // locally held registers; no partition register exists
   function automatic logic is_own(input logic [7:0] a);
      unique case (a)
         `SAG_PROGRAM_STATUS_HIGH, `SAG_SEGT_L, `SAG_SEGT_H, `SAG_FWR_L, `SAG_FWR_H,
         `SAG_XB_L, `SAG_XB_H, `SAG_XS_L, `SAG_XS_H: is_own = 1'h1;
         default: is_own = 1'h0;
      endcase
   endfunction

   function automatic logic [7:0] own_rd(input sag_state_t s, input logic [7:0] a);
      unique case (a)
         `SAG_PROGRAM_STATUS_HIGH:   own_rd = s.psw;
         `SAG_SEGT_L: own_rd = s.segt[7:0];
         `SAG_SEGT_H: own_rd = s.segt[15:8];
         `SAG_FWR_L:  own_rd = s.fwr[7:0];
         `SAG_FWR_H:  own_rd = s.fwr[15:8];
         `SAG_XB_L:   own_rd = s.xb[7:0];
         `SAG_XB_H:   own_rd = s.xb[15:8];
         `SAG_XS_L:   own_rd = s.xs[7:0];
         `SAG_XS_H:   own_rd = s.xs[15:8];
         default:     own_rd = 8'h00;
      endcase
   endfunction

   // bus read mux: {resp, data}
   function automatic logic [33:0] bus_rd(input sag_state_t s, input logic [7:0] a);
      unique case (a)
         `SAG_AX_CTRL: bus_rd = {`SAG_OKAY, 31'h0, s.log_en};
         `SAG_AX_STAT: bus_rd = {`SAG_OKAY, 29'h0, s.mode};
         `SAG_AX_DENY: bus_rd = {`SAG_OKAY, 16'h0, s.deny_cnt};
         `SAG_AX_LAST: bus_rd = {`SAG_OKAY, 20'h0, s.last};
         `SAG_AX_FWR:  bus_rd = {`SAG_OKAY, 16'h0, s.fwr};
         `SAG_AX_XB:   bus_rd = {`SAG_OKAY, 16'h0, s.xb};
         `SAG_AX_XS:   bus_rd = {`SAG_OKAY, 16'h0, s.xs};
         `SAG_AX_SEGT: bus_rd = {`SAG_OKAY, 16'h0, s.segt};
         default:      bus_rd = {`SAG_SLVERR, 32'h0};
      endcase
   endfunction

   assign own   = is_own(cpu_addr);
   assign lread = own_rd(q, cpu_addr);

   always_comb begin
      n = q;
      // bus slave: address and data in either order
      if (q.bvalid && s_axi_bready) n.bvalid = 1'h0;
      if (s_axi_awvalid && q.awready) begin
         n.aw_got  = 1'h1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         n.w_got   = 1'h1;
         n.w_data  = s_axi_wdata;
         n.w_strb0 = s_axi_wstrb[0];
      end
      if (q.aw_got && q.w_got) begin
         n.aw_got = 1'h0;
         n.w_got  = 1'h0;
         n.bvalid = 1'h1;
         n.bresp  = `SAG_OKAY;
         unique case (q.aw_addr)
            `SAG_AX_CTRL: begin
               if (q.w_strb0) begin
                  n.log_en = q.w_data[`SAG_CTRL_LOG];
                  if (q.w_data[`SAG_CTRL_CLR]) n.deny_cnt = 16'h0000;
               end
            end
            `SAG_AX_STAT, `SAG_AX_DENY, `SAG_AX_LAST, `SAG_AX_FWR,
            `SAG_AX_XB, `SAG_AX_XS, `SAG_AX_SEGT: n.bresp = `SAG_OKAY;
            default: n.bresp = `SAG_SLVERR;
         endcase
      end
      if (q.rvalid && s_axi_rready) n.rvalid = 1'h0;
      if (s_axi_arvalid && q.arready) begin
         n.rvalid            = 1'h1;
         {n.rresp, n.rdata} = bus_rd(q, s_axi_araddr);
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready  = !n.w_got && !n.bvalid;
      n.arready = !n.rvalid;

      // answer stage: denied reads give zero
      n.c_ack    = q.s_vld;
      n.c_denied = q.s_vld && !q.s_ok;
      n.c_rdata  = 8'h00;
      if (q.s_vld && q.s_ok && !q.s_wr) begin
         n.c_rdata = q.s_own ? q.s_ldata : sfr_rdata;
      end

      // request stage, decided with the issuing mode
      n.mode  = cur_mode;
      n.s_vld = cpu_req;
      n.s_rd  = 1'h0;
      n.s_wr  = 1'h0;
      if (cpu_req) begin
         n.s_addr  = cpu_addr;
         n.s_wdata = cpu_wdata;
         n.s_ok    = grant;
         n.s_own   = own;
         n.s_ldata = cpu_wr ? 8'h00 : lread;
         n.s_rd    = grant && !own && !cpu_wr;
         n.s_wr    = grant && !own && cpu_wr;
         if (grant && cpu_wr) begin
            unique case (cpu_addr)
               `SAG_PROGRAM_STATUS_HIGH:   n.psw       = cpu_wdata;
               `SAG_SEGT_L: n.segt[7:0]  = cpu_wdata;
               `SAG_SEGT_H: n.segt[15:8] = cpu_wdata;
               `SAG_FWR_L:  n.fwr[7:0]   = cpu_wdata;
               `SAG_FWR_H:  n.fwr[15:8]  = cpu_wdata;
               `SAG_XB_L:   n.xb[7:0]    = cpu_wdata;
               `SAG_XB_H:   n.xb[15:8]   = cpu_wdata;
               `SAG_XS_L:   n.xs[7:0]    = cpu_wdata;
               `SAG_XS_H:   n.xs[15:8]   = cpu_wdata;
               default:     n.psw        = q.psw;
            endcase
         end
         if (!grant && q.log_en) begin
            n.deny_cnt = n.deny_cnt + 16'h0001;
            n.last     = {cur_mode, cpu_wr, cpu_addr};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= SAG_RST;
      end else begin
         q <= n;
      end
   end

   assign cpu_ack        = q.c_ack;
   assign cpu_denied     = q.c_denied;
   assign cpu_rdata      = q.c_rdata;
   assign cpu_mode       = q.mode;
   assign sfr_rd         = q.s_rd;
   assign sfr_wr         = q.s_wr;
   assign sfr_addr       = q.s_addr;
   assign sfr_wdata      = q.s_wdata;
   // table contents live in memory; only the pointer is here
   assign seg_table_addr = q.segt;
   assign xchg_base      = q.xb;
   assign xchg_size      = q.xs;
   assign s_axi_awready  = q.awready;
   assign s_axi_wready   = q.wready;
   assign s_axi_bvalid   = q.bvalid;
   assign s_axi_bresp    = q.bresp;
   assign s_axi_arready  = q.arready;
   assign s_axi_rvalid   = q.rvalid;
   assign s_axi_rresp    = q.rresp;
   assign s_axi_rdata    = q.rdata;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_take(c);
      cpu_req && c;
   endsequence
   sequence s_granted;
      cpu_ack && !cpu_denied;
   endsequence
   sequence s_refused;
      cpu_ack && cpu_denied && cpu_rdata == 8'h00;
   endsequence
   sequence s_silent;
      !sfr_rd && !sfr_wr;
   endsequence

   a_boot_grant:
      assert property (s_take(cur_mode == SAG_BOOT && cpu_addr >= `SAG_CLOS_LO
         && cpu_addr < `SAG_HW_LO) |-> ##2 s_granted)
      else $error("boot access refused");
   a_test_grant:
      assert property (s_take(cur_mode == SAG_TEST && cpu_addr == `SAG_FWR_L)
         |-> ##2 s_granted)
      else $error("test access refused");
   a_clos_fw_wr:
      assert property (s_take(cur_mode == SAG_CLOS && cpu_wr && cpu_addr >= `SAG_FW_LO
         && cpu_addr < `SAG_CLOS_LO) |-> ##1 !sfr_wr ##1 s_refused)
      else $error("firewall write allowed in contactless mode");
   a_clos_hw_right:
      assert property (s_take(cur_mode == SAG_CLOS && cpu_addr >= `SAG_HW_LO
         && !q.fwr[cpu_addr[`SAG_HW_IDX]] && cpu_addr != `SAG_CLOCK_SELECTION_REG)
         |-> ##2 s_refused)
      else $error("hardware access without firewall right");
   a_sys_segt_wr:
      assert property (s_take(cur_mode == SAG_SYS && cpu_wr && cpu_addr == `SAG_SEGT_L)
         |=> seg_table_addr[7:0] == $past(cpu_wdata) ##1 s_granted)
      else $error("system write to table pointer lost");
   a_user_segt_keep:
      assert property (s_take(cur_mode == SAG_USER && cpu_wr && cpu_addr == `SAG_SEGT_H)
         |=> $stable(seg_table_addr) ##1 s_refused)
      else $error("user changed table pointer");
   a_user_hw_right:
      assert property (s_take(cur_mode == SAG_USER && !cpu_wr && cpu_addr == `SAG_CLOCK_SELECTION_REG
         && seg_hw_rights[cpu_addr[`SAG_HW_IDX]]) |-> ##1 sfr_rd ##1 s_granted)
      else $error("user hardware read refused");
   a_gen_open:
      assert property (s_take(cpu_addr < `SAG_SYS_LO) |-> ##2 s_granted)
      else $error("general register refused");
   a_psw_read:
      assert property (s_take(!cpu_wr && cpu_addr == `SAG_PROGRAM_STATUS_HIGH) |-> ##2 s_granted)
      else $error("status read refused");
   a_clock_selection_reg_read:
      assert property (s_take(cur_mode == SAG_CLOS && !cpu_wr && cpu_addr == `SAG_CLOCK_SELECTION_REG)
         |-> ##2 s_granted)
      else $error("clock selection read refused");
   a_rsv_read:
      assert property (s_take(!cpu_wr && cpu_addr >= `SAG_RSV0 && cpu_addr <= `SAG_RSV2)
         |-> ##1 !sfr_rd ##1 s_refused)
      else $error("reserved register readable");
   a_rng_write:
      assert property (s_take(cpu_wr && cpu_addr == `SAG_RNG) |=> !sfr_wr)
      else $error("random number write passed");
   a_key_read:
      assert property (s_take(!cpu_wr && (cpu_addr == `SAG_KEYA || cpu_addr == `SAG_KEYD))
         |-> ##2 s_refused)
      else $error("key register readable");
   a_seg_reset:
      assert property (@(posedge aclk) disable iff (1'b0) !aresetn
         |=> seg_table_addr == 16'h0000)
      else $error("table pointer not cleared by reset");

   a_sys_fw_grant:
      assert property (s_take(cur_mode == SAG_SYS && cpu_addr >= `SAG_FW_LO
         && cpu_addr < `SAG_CLOS_LO) |-> ##2 s_granted)
      else $error("system firewall access refused");
   a_clos_own:
      assert property (s_take(cur_mode == SAG_CLOS && cpu_addr >= `SAG_CLOS_LO
         && cpu_addr < `SAG_HW_LO) |-> ##2 s_granted)
      else $error("contactless register access refused");
   a_clos_fw_read:
      assert property (s_take(cur_mode == SAG_CLOS && !cpu_wr && cpu_addr >= `SAG_FW_LO
         && cpu_addr < `SAG_CLOS_LO) |-> ##2 s_granted)
      else $error("firewall read refused in contactless mode");
   a_seg_closed:
      assert property (s_take(cur_mode != SAG_SYS && cpu_addr >= `SAG_SEG_LO
         && cpu_addr < `SAG_FW_LO) |-> ##1 s_silent ##1 s_refused)
      else $error("segmentation register open outside system mode");
   a_deny_quiet:
      assert property (s_take(!grant) |-> ##1 s_silent ##1 s_refused)
      else $error("denied access reached the register file");
   a_deny_keep:
      assert property (s_take(!grant && cpu_wr) |=> $stable(seg_table_addr)
         && $stable(xchg_base) && $stable(xchg_size) && $stable(q.psw) && $stable(q.fwr))
      else $error("denied write changed a local register");
   a_user_win_keep:
      assert property (s_take(cur_mode == SAG_USER && cpu_wr && cpu_addr >= `SAG_FW_LO
         && cpu_addr < `SAG_CLOS_LO) |=> $stable(xchg_base) && $stable(xchg_size))
      else $error("user changed the exchange window");
   a_win_write:
      assert property (s_take(grant && cpu_wr && cpu_addr == `SAG_XB_L)
         |=> xchg_base[7:0] == $past(cpu_wdata))
      else $error("exchange base write lost");
   a_ack_delay:
      assert property (s_take(1'b1) |-> ##2 cpu_ack)
      else $error("access not answered");
   a_boot_prio:
      assert property (boot_state |=> cpu_mode == SAG_BOOT)
      else $error("boot mode not derived");
   a_clos_prio:
      assert property (!boot_state && !test_state && q.psw[`SAG_PSW_CLOS]
         |=> cpu_mode == SAG_CLOS)
      else $error("contactless mode not derived");
endmodule // sag_guard
`default_nettype wire

/* bench/sag_sfr_model.sv */
// behavioural register file behind the sfr access guard
`timescale 1ns/1ps
`default_nettype none
module sag_sfr_model (
   // clock
   input  wire logic       aclk,
   // strobes from the guard
   input  wire logic       sfr_rd,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   // read data
   output logic [7:0]      sfr_rdata
);
   logic [7:0] mem [256];
   logic [7:0] held;
   initial begin
      held = 8'h00;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5A;
   end
   // outside a strobe the data lines show the inverse of the last read
   assign sfr_rdata = sfr_rd ? mem[sfr_addr] : ~held;
   always @(posedge aclk) begin
      if (sfr_rd)
         held <= mem[sfr_addr];
      if (sfr_wr)
         mem[sfr_addr] <= sfr_wdata;
   end
endmodule // sag_sfr_model
`default_nettype wire

/* bench/tb_sfr_access_guard.sv */
// self-checking bench for the sfr access guard
`timescale 1ns/1ps
`default_nettype none
`include "sag_map.svh"
module tb_sfr_access_guard import sag_pkg::*;;
   logic        aclk = 1'b0, aresetn = 1'b0, cpu_req = 1'b0, cpu_wr = 1'b0;
   logic        boot_state = 1'b0, test_state = 1'b0, cpu_ack, cpu_denied, sfr_rd, sfr_wr;
   logic [7:0]  cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata, sfr_addr, sfr_wdata, sfr_rdata;
   logic [15:0] seg_hw_rights = 16'hA5A5, seg_table_addr, xchg_base, xchg_size;
   logic [2:0]  cpu_mode;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          failures = 0, checks_done = 0, cycles = 0, denies = 0;
   logic [7:0]  shadow [256];
   logic [11:0] last_den = 12'h000;

   sag_guard DUT (.aclk, .aresetn, .cpu_req, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_ack,
      .cpu_denied, .cpu_rdata, .boot_state, .test_state, .seg_hw_rights, .cpu_mode, .sfr_rd,
      .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata, .seg_table_addr, .xchg_base, .xchg_size,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   sag_sfr_model u_sfr (.aclk, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata);

   always #50 aclk = ~aclk;

   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic sag_mode_t emode();
      if (boot_state) return SAG_BOOT;
      if (test_state) return SAG_TEST;
      if (shadow[`SAG_PROGRAM_STATUS_HIGH][`SAG_PSW_CLOS]) return SAG_CLOS;
      if (shadow[`SAG_PROGRAM_STATUS_HIGH][`SAG_PSW_SYS]) return SAG_SYS;
      return SAG_USER;
   endfunction

   function automatic logic egrant(sag_mode_t m, logic [7:0] a, logic w);
      logic [15:0] fw;
      fw = {shadow[`SAG_FWR_H], shadow[`SAG_FWR_L]};
      if (a < `SAG_SYS_LO) return 1'b1;
      if (a >= `SAG_SEG_LO && a < `SAG_FW_LO) return m == SAG_SYS;
      if (!w && ((a >= `SAG_RSV0 && a <= `SAG_RSV2) || a == `SAG_KEYA || a == `SAG_KEYD))
         return 1'b0;
      if (w && a == `SAG_RNG) return 1'b0;
      if (m == SAG_BOOT || m == SAG_TEST) return 1'b1;
      if (m == SAG_SYS) return a < `SAG_CLOS_LO || a >= `SAG_HW_LO;
      if (a < `SAG_SEG_LO) return !w && a == `SAG_PROGRAM_STATUS_HIGH;
      if (a < `SAG_CLOS_LO) return !w && m == SAG_CLOS;
      if (a < `SAG_HW_LO) return m == SAG_CLOS;
      if (m == SAG_CLOS) return (!w && a == `SAG_CLOCK_SELECTION_REG) || fw[a[5:2]];
      return seg_hw_rights[a[5:2]];
   endfunction

   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic g;
      sag_mode_t m;
      m = emode();
      g = egrant(m, a, w);
      @(posedge aclk);
      cpu_req <= 1'b1;
      cpu_wr <= w;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge aclk);
      cpu_req <= 1'b0;
      @(posedge aclk);
      #1;
      chk(32'(cpu_ack), 32'h1);
      chk(32'(cpu_denied), 32'(!g));
      chk(32'(cpu_rdata), (g && !w) ? 32'(shadow[a]) : 32'h0);
      if (g && w)
         shadow[a] = d;
      if (!g) begin
         denies++;
         last_den = {m, w, a};
      end
   endtask

   task automatic sweep(input logic w);
      for (int i = 128; i < 256; i++)
         if (!(w && i == `SAG_PROGRAM_STATUS_HIGH))
            acc(w, 8'(i), 8'(i) ^ 8'hC3);
   endtask

   task automatic setm(input logic b, input logic t);
      @(posedge aclk);
      boot_state <= b;
      test_state <= t;
      repeat (3) @(posedge aclk);
      #1;
      chk(32'(cpu_mode), 32'(emode()));
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do
         @(posedge aclk);
      while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
   endtask

   task automatic outchk();
      chk(32'(seg_table_addr), {16'h0, shadow[`SAG_SEGT_H], shadow[`SAG_SEGT_L]});
      chk(32'(xchg_base), {16'h0, shadow[`SAG_XB_H], shadow[`SAG_XB_L]});
      chk(32'(xchg_size), {16'h0, shadow[`SAG_XS_H], shadow[`SAG_XS_L]});
      rdchk(`SAG_AX_SEGT, {16'h0, shadow[`SAG_SEGT_H], shadow[`SAG_SEGT_L]}, `SAG_OKAY);
   endtask

   initial begin
      logic [1:0] r;
      for (int i = 0; i < 256; i++)
         shadow[i] = (i == `SAG_PROGRAM_STATUS_HIGH || (i >= 8'hA8 && i < 8'hAE) || i < 8'hA2 && i >= 8'hA0)
                     ? 8'h00 : 8'(i) ^ 8'h5A;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      outchk();
      rdchk(`SAG_AX_CTRL, 32'h1, `SAG_OKAY);
      rdchk(`SAG_AX_STAT, 32'(SAG_USER), `SAG_OKAY);
      rdchk(8'h20, 32'h0, `SAG_SLVERR);
      axi_wr(`SAG_AX_CTRL, 32'h3, r);
      chk(32'(r), 32'(`SAG_OKAY));
      axi_wr(8'h20, 32'h0, r);
      chk(32'(r), 32'(`SAG_SLVERR));
      axi_wr(`SAG_AX_SEGT, 32'hFFFF, r);
      chk(32'(r), 32'(`SAG_OKAY));
      setm(1'b0, 1'b0);
      sweep(1'b0);
      sweep(1'b1);
      acc(1'b1, `SAG_PROGRAM_STATUS_HIGH, 8'h80);
      outchk();
      setm(1'b1, 1'b0);
      sweep(1'b1);
      sweep(1'b0);
      acc(1'b1, `SAG_PROGRAM_STATUS_HIGH, 8'h40);
      setm(1'b0, 1'b1);
      sweep(1'b1);
      sweep(1'b0);
      acc(1'b1, `SAG_FWR_L, 8'h6A);
      setm(1'b0, 1'b0);
      sweep(1'b1);
      sweep(1'b0);
      acc(1'b1, `SAG_PROGRAM_STATUS_HIGH, 8'h80);
      setm(1'b1, 1'b0);
      acc(1'b1, `SAG_PROGRAM_STATUS_HIGH, 8'h80);
      setm(1'b0, 1'b0);
      sweep(1'b1);
      sweep(1'b0);
      outchk();
      acc(1'b1, `SAG_PROGRAM_STATUS_HIGH, 8'h00);
      @(posedge aclk);
      seg_hw_rights <= 16'h5A3C;
      setm(1'b0, 1'b0);
      sweep(1'b1);
      sweep(1'b0);
      outchk();
      rdchk(`SAG_AX_DENY, 32'(denies[15:0]), `SAG_OKAY);
      rdchk(`SAG_AX_LAST, 32'(last_den), `SAG_OKAY);
      print_verdict();
   end
endmodule // tb_sfr_access_guard
`default_nettype wire
